/* File: hw/srpf_filter.sv */
// Notes on behaviour
// - Resume restarts the paused operation and clears whichever pause flag was set.
// - Four-bit mode instruction is two nibbles, upper nibble first.
// - While paused, single-rate array reads of all widths are accepted.
// - While paused, double-rate reads are accepted.
// - While paused, status, function, bank and parameter register reads are accepted.
// - While paused, all identification reads are accepted.
// - While paused, write enable, write disable and error-flag clear are accepted.
// - While paused, volatile settings writes and address-width changes are accepted.
// - While paused, protection reads are accepted.
// - While paused, training pattern and ECC register read or clear are accepted.
// - Only during erase pause, page program instructions are accepted.
// - Only during erase pause, sector lock, unlock, protection and ECC writes are accepted.
// - Power-down entry completes within the entry time after chip select rises.
// - Power-down engages only if chip select rises right after a complete instruction.
// - In power-down only the release instruction is recognised.
// - Power-down entry works in single-bit and four-bit command modes.
// - Program pause shows in function bit 2, erase pause in bit 3.
// - During erase pause, reads of the erasing sector and erases are refused.
// - Leaving power-down takes the release time before instructions are accepted.
`timescale 1ns/100ps
`default_nettype none

module srpf_filter (
  input wire logic clk_i,                       // System clock, 10 MHz
  input wire logic rst_n_i,                     // Synchronous reset, active low
  input wire logic cs_n_i,                      // Chip select pin, active low
  input wire logic sck_i,                       // Serial clock pin
  input wire logic [3:0] io_i,                  // Data pins, io_i[0] is serial input
  input wire logic quad_command_mode_i,         // Four-bit command mode is on
  input wire logic write_in_progress_flag_i,    // Self-timed operation is busy
  input wire logic erase_suspend_set_i,         // Pulse: an erase has been paused
  input wire logic program_suspend_set_i,       // Pulse: a program has been paused
  input wire logic erase_hit_i,                 // Read address lies in the erasing sector
  output logic cmd_valid_o,                     // Pulse: instruction accepted
  output logic [7:0] cmd_code_o,                // Last latched instruction code
  output logic cmd_refused_o,                   // Pulse: instruction ignored
  output logic resume_o,                        // Pulse: restart the paused operation
  output logic read_block_o,                    // Current array read must be refused
  output logic power_down_o,                    // Low-power state or release pending
  output logic erase_paused_flag_o,             // Erase is paused
  output logic program_paused_flag_o,           // Program is paused
  output logic [7:0] function_reg_bits_o        // Pause bits in function register place
);

  import srpf_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection

  logic [5:0] pins;
  logic cs_s;
  logic sck_s;
  logic [3:0] io_s;
  logic sck_prev;
  logic cs_prev;
  logic sck_rise;
  logic frame_end;

  srpf_sync #(
    .W(6),
    .INIT(PIN_RESET_VALUE)
  ) u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .d_i({cs_n_i, sck_i, io_i}),
    .q_o(pins)
  );

  assign cs_s = pins[5];
  assign sck_s = pins[4];
  assign io_s = pins[3:0];

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sck_prev <= 1'b0;
      cs_prev <= 1'b1;
    end else begin
      sck_prev <= sck_s;
      cs_prev <= cs_s;
    end
  end

  assign sck_rise = ~cs_s & sck_s & ~sck_prev;
  assign frame_end = cs_s & ~cs_prev;

  //////////////////////////////////////////////////////////////////////////////
  // Instruction shifter

  logic [7:0] shreg;
  logic [7:0] next_shreg;
  logic [3:0] bit_cnt;
  logic [3:0] next_cnt;
  logic over;
  logic latch;
  logic exact;

  always_comb begin
    if (quad_command_mode_i) begin
      next_shreg = {shreg[3:0], io_s};
      next_cnt = bit_cnt + QUAD_STEP;
    end else begin
      next_shreg = {shreg[6:0], io_s[0]};
      next_cnt = bit_cnt + SPI_STEP;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i || cs_s) begin
      shreg <= 8'h00;
      bit_cnt <= 4'h0;
      over <= 1'b0;
    end else if (sck_rise) begin
      if (bit_cnt == INSTR_BITS) begin
        over <= 1'b1;
      end else begin
        shreg <= next_shreg;
        bit_cnt <= next_cnt;
      end
    end
  end

  assign latch = sck_rise && (bit_cnt != INSTR_BITS) && (next_cnt == INSTR_BITS);
  assign exact = (bit_cnt == INSTR_BITS) && !over;

  //////////////////////////////////////////////////////////////////////////////
  // Instruction classes while paused

  function automatic srpf_class_t srpf_classify(input logic [7:0] op);
    case (op)
      OP_NORMAL_ARRAY_READ,
      OP_NORMAL_ARRAY_READ4,
      OP_FAST_ARRAY_READ,
      OP_FAST_ARRAY_READ4,
      OP_DUAL_IO_ARRAY_READ,
      OP_DUAL_IO_ARRAY_READ4,
      OP_DUAL_OUT_READ,
      OP_DUAL_OUT_READ4,
      OP_QUAD_IO_ARRAY_READ,
      OP_QUAD_IO_ARRAY_READ4,
      OP_QUAD_OUT_READ,
      OP_QUAD_OUT_READ4: srpf_classify = CL_READ;
      OP_DOUBLE_RATE_ARRAY_READ,
      OP_DOUBLE_RATE_ARRAY_READ4,
      OP_DOUBLE_RATE_DUAL_READ,
      OP_DOUBLE_RATE_DUAL_READ4,
      OP_DOUBLE_RATE_QUAD_READ,
      OP_DOUBLE_RATE_QUAD_READ4: srpf_classify = CL_READ;
      OP_STATUS_REG_READ,
      OP_FUNCTION_REG_READ,
      OP_BANK_REG_READ_A,
      OP_BANK_REG_READ_B,
      OP_READ_PARAM_REG_READ,
      OP_EXT_PARAM_REG_READ: srpf_classify = CL_BOTH;
      OP_RELEASE_SIGNATURE_CMD,
      OP_STD_ID_READ,
      OP_MAKER_DEV_ID_READ,
      OP_QUAD_ID_READ,
      OP_UNIQUE_ID_READ,
      OP_PARAM_TABLE_READ: srpf_classify = CL_BOTH;
      OP_WRITE_ENABLE,
      OP_WRITE_DISABLE,
      OP_ERROR_FLAG_CLEAR_CMD: srpf_classify = CL_BOTH;
      OP_VOLATILE_PARAM_WRITE_A,
      OP_VOLATILE_PARAM_WRITE_B,
      OP_VOLATILE_EXT_PARAM_WRITE,
      OP_VOLATILE_BANK_WRITE_A,
      OP_VOLATILE_BANK_WRITE_B,
      OP_WIDE_ADDRESS_ENTER,
      OP_WIDE_ADDRESS_EXIT: srpf_classify = CL_BOTH;
      OP_PERSISTENT_PROT_READ,
      OP_PERSISTENT_PROT_READ4,
      OP_DYNAMIC_PROT_READ,
      OP_DYNAMIC_PROT_4,
      OP_PASSWORD_READ,
      OP_PROT_LOCK_READ,
      OP_PROT_MODE_READ: srpf_classify = CL_BOTH;
      OP_TRAINING_PATTERN_READ,
      OP_TRAINING_PATTERN_WRITE,
      OP_ECC_REG_CLEAR,
      OP_ECC_REG_READ: srpf_classify = CL_BOTH;
      OP_RESUME_CMD_A,
      OP_RESUME_CMD_B: srpf_classify = CL_BOTH;
      OP_PAGE_PROGRAM_CMD,
      OP_PAGE_PROGRAM_CMD4,
      OP_QUAD_PAGE_PROGRAM_CMD,
      OP_QUAD_PAGE_PROGRAM_CMD4,
      OP_QUAD_IO_PAGE_PROGRAM,
      OP_QUAD_IO_PAGE_PROGRAM4: srpf_classify = CL_ERASE;
      OP_SECTOR_LOCK_CMD,
      OP_SECTOR_UNLOCK_CMD,
      OP_SECTOR_UNLOCK_CMD4,
      OP_DYNAMIC_PROT_WRITE,
      OP_ECC_REG_WRITE,
      OP_SUSPEND_CMD_A,
      OP_SUSPEND_CMD_B: srpf_classify = CL_ERASE;
      default: srpf_classify = CL_NONE;
    endcase
  endfunction : srpf_classify

  //////////////////////////////////////////////////////////////////////////////
  // Acceptance decision

  srpf_state_t state;
  srpf_class_t lat_class;
  logic suspended;
  logic class_ok;
  logic lat_resume;
  logic lat_pd;
  logic defer;
  logic gate_ok;
  logic held_defer;
  logic read_active;
  logic end_resume;
  logic end_pd;
  logic do_dp;
  logic do_res;
  logic do_wake;

  assign suspended = erase_paused_flag_o | program_paused_flag_o;
  assign lat_class = srpf_classify(next_shreg);
  assign lat_resume = (next_shreg == OP_RESUME_CMD_A) || (next_shreg == OP_RESUME_CMD_B);
  assign lat_pd = (next_shreg == OP_POWER_DOWN_ENTRY_CMD);

  always_comb begin
    case (lat_class)
      CL_BOTH: class_ok = 1'b1;
      CL_READ: class_ok = 1'b1;
      CL_ERASE: class_ok = erase_paused_flag_o;
      default: class_ok = 1'b0;
    endcase
  end

  // Resume, power-down entry and release act only on a clean frame end
  assign defer = ((state == ST_ACTIVE) && (lat_resume || lat_pd))
    || ((state == ST_PD) && (next_shreg == OP_RELEASE_SIGNATURE_CMD));
  assign gate_ok = (state == ST_ACTIVE) && (!suspended || class_ok);

  assign end_resume = (shreg == OP_RESUME_CMD_A) || (shreg == OP_RESUME_CMD_B);
  assign end_pd = (shreg == OP_POWER_DOWN_ENTRY_CMD);
  assign do_dp = frame_end && exact && held_defer && (state == ST_ACTIVE) && end_pd && !suspended;
  assign do_res = frame_end && exact && held_defer && (state == ST_ACTIVE) && end_resume && suspended;
  assign do_wake = frame_end && exact && held_defer && (state == ST_PD)
    && (shreg == OP_RELEASE_SIGNATURE_CMD);

  always_ff @(posedge clk_i) begin
    if (!rst_n_i || cs_s) begin
      held_defer <= 1'b0;
      read_active <= 1'b0;
    end else if (latch) begin
      held_defer <= defer;
      read_active <= gate_ok && !defer && (lat_class == CL_READ);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cmd_valid_o <= 1'b0;
      cmd_code_o <= 8'h00;
      cmd_refused_o <= 1'b0;
      read_block_o <= 1'b0;
    end else begin
      cmd_valid_o <= latch && gate_ok && !defer;
      cmd_refused_o <= (latch && !gate_ok && !defer)
        || (frame_end && held_defer && !(do_dp || do_res || do_wake));
      read_block_o <= read_active && !cs_s && erase_paused_flag_o && erase_hit_i;
      if (latch) begin
        cmd_code_o <= next_shreg;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pause flags

  logic next_erase_paused;
  logic next_program_paused;

  // A new pause wins over a resume in the same cycle
  assign next_erase_paused = erase_suspend_set_i || (erase_paused_flag_o && !do_res);
  assign next_program_paused = program_suspend_set_i || (program_paused_flag_o && !do_res);

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      erase_paused_flag_o <= 1'b0;
      program_paused_flag_o <= 1'b0;
      function_reg_bits_o <= 8'h00;
      resume_o <= 1'b0;
    end else begin
      erase_paused_flag_o <= next_erase_paused;
      program_paused_flag_o <= next_program_paused;
      function_reg_bits_o <= 8'h00;
      function_reg_bits_o[FUNC_PROGRAM_PAUSED_BIT] <= next_program_paused;
      function_reg_bits_o[FUNC_ERASE_PAUSED_BIT] <= next_erase_paused;
      resume_o <= do_res;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Power-down sequencer

  logic [7:0] pd_cnt;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state <= ST_ACTIVE;
      pd_cnt <= 8'h00;
      power_down_o <= 1'b0;
    end else begin
      case (state)
        ST_ACTIVE: begin
          if (do_dp) begin
            state <= ST_PD_ENTRY;
            // Entry time counts from the chip select pin, so the pin latency comes off
            pd_cnt <= POWER_DOWN_ENTRY_CYC - PIN_LATENCY_CYC;
          end
        end
        ST_PD_ENTRY: begin
          if (pd_cnt == 8'h00) begin
            state <= ST_PD;
            power_down_o <= 1'b1;
          end else begin
            pd_cnt <= pd_cnt - 8'h01;
          end
        end
        ST_PD: begin
          if (do_wake) begin
            state <= ST_PD_EXIT;
            pd_cnt <= POWER_DOWN_EXIT_CYC - 8'h01;
          end
        end
        ST_PD_EXIT: begin
          if (pd_cnt == 8'h00) begin
            state <= ST_ACTIVE;
            power_down_o <= 1'b0;
          end else begin
            pd_cnt <= pd_cnt - 8'h01;
          end
        end
        default: begin
          state <= ST_ACTIVE;
          power_down_o <= 1'b0;
        end
      endcase
    end
  end

  // Busy status is the neighbour's; it only gates suspend timing on the host side
  logic unused_wip;
  assign unused_wip = write_in_progress_flag_i;

endmodule : srpf_filter

`default_nettype wire

/* File: hw/srpf_pkg.sv */
package srpf_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_FREQ_MHZ = 10;
  localparam int POWER_DOWN_ENTRY_TIME_NS = 3000;
  localparam int POWER_DOWN_EXIT_TIME_NS = 5000;
  // Entry is a longest time (round down), exit a least time (round up)
  localparam logic [7:0] POWER_DOWN_ENTRY_CYC = 8'((POWER_DOWN_ENTRY_TIME_NS * CLK_FREQ_MHZ) / 1000);
  localparam logic [7:0] POWER_DOWN_EXIT_CYC = 8'((POWER_DOWN_EXIT_TIME_NS * CLK_FREQ_MHZ + 999) / 1000);
  // Cycles from a chip select pin edge until the sequencer's count has its first step
  localparam logic [7:0] PIN_LATENCY_CYC = 8'h06;

  ////////////////////////////////////////////////////////////////////////////
  // Framing and function register layout
  localparam logic [3:0] INSTR_BITS = 4'h8;
  localparam logic [3:0] SPI_STEP = 4'h1;
  localparam logic [3:0] QUAD_STEP = 4'h4;
  localparam int FUNC_PROGRAM_PAUSED_BIT = 2;
  localparam int FUNC_ERASE_PAUSED_BIT = 3;
  localparam logic [5:0] PIN_RESET_VALUE = 6'h20;

  ////////////////////////////////////////////////////////////////////////////
  // Instruction codes
  localparam logic [7:0] OP_NORMAL_ARRAY_READ = 8'h03;
  localparam logic [7:0] OP_NORMAL_ARRAY_READ4 = 8'h13;
  localparam logic [7:0] OP_FAST_ARRAY_READ = 8'h0b;
  localparam logic [7:0] OP_FAST_ARRAY_READ4 = 8'h0c;
  localparam logic [7:0] OP_DUAL_IO_ARRAY_READ = 8'hbb;
  localparam logic [7:0] OP_DUAL_IO_ARRAY_READ4 = 8'hbc;
  localparam logic [7:0] OP_DUAL_OUT_READ = 8'h3b;
  localparam logic [7:0] OP_DUAL_OUT_READ4 = 8'h3c;
  localparam logic [7:0] OP_QUAD_IO_ARRAY_READ = 8'heb;
  localparam logic [7:0] OP_QUAD_IO_ARRAY_READ4 = 8'hec;
  localparam logic [7:0] OP_QUAD_OUT_READ = 8'h6b;
  localparam logic [7:0] OP_QUAD_OUT_READ4 = 8'h6c;
  localparam logic [7:0] OP_DOUBLE_RATE_ARRAY_READ = 8'h0d;
  localparam logic [7:0] OP_DOUBLE_RATE_ARRAY_READ4 = 8'h0e;
  localparam logic [7:0] OP_DOUBLE_RATE_DUAL_READ = 8'hbd;
  localparam logic [7:0] OP_DOUBLE_RATE_DUAL_READ4 = 8'hbe;
  localparam logic [7:0] OP_DOUBLE_RATE_QUAD_READ = 8'hed;
  localparam logic [7:0] OP_DOUBLE_RATE_QUAD_READ4 = 8'hee;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_STATUS_REG_READ = 8'h05;
  localparam logic [7:0] OP_FUNCTION_REG_READ = 8'h48;
  localparam logic [7:0] OP_BANK_REG_READ_A = 8'h16;
  localparam logic [7:0] OP_BANK_REG_READ_B = 8'hc8;
  localparam logic [7:0] OP_READ_PARAM_REG_READ = 8'h61;
  localparam logic [7:0] OP_EXT_PARAM_REG_READ = 8'h81;
  localparam logic [7:0] OP_RELEASE_SIGNATURE_CMD = 8'hab;
  localparam logic [7:0] OP_STD_ID_READ = 8'h9f;
  localparam logic [7:0] OP_MAKER_DEV_ID_READ = 8'h90;
  localparam logic [7:0] OP_QUAD_ID_READ = 8'haf;
  localparam logic [7:0] OP_UNIQUE_ID_READ = 8'h4b;
  localparam logic [7:0] OP_PARAM_TABLE_READ = 8'h5a;
  localparam logic [7:0] OP_ERROR_FLAG_CLEAR_CMD = 8'h82;
  localparam logic [7:0] OP_RESUME_CMD_A = 8'h7a;
  localparam logic [7:0] OP_RESUME_CMD_B = 8'h30;
  localparam logic [7:0] OP_VOLATILE_PARAM_WRITE_A = 8'hc0;
  localparam logic [7:0] OP_VOLATILE_PARAM_WRITE_B = 8'h63;
  localparam logic [7:0] OP_VOLATILE_EXT_PARAM_WRITE = 8'h83;
  localparam logic [7:0] OP_VOLATILE_BANK_WRITE_A = 8'h17;
  localparam logic [7:0] OP_VOLATILE_BANK_WRITE_B = 8'hc5;
  localparam logic [7:0] OP_WIDE_ADDRESS_ENTER = 8'hb7;
  localparam logic [7:0] OP_WIDE_ADDRESS_EXIT = 8'h29;
  localparam logic [7:0] OP_PERSISTENT_PROT_READ = 8'hfc;
  localparam logic [7:0] OP_PERSISTENT_PROT_READ4 = 8'hf2;
  localparam logic [7:0] OP_DYNAMIC_PROT_READ = 8'hfa;
  localparam logic [7:0] OP_DYNAMIC_PROT_4 = 8'he0;
  localparam logic [7:0] OP_PASSWORD_READ = 8'he7;
  localparam logic [7:0] OP_PROT_LOCK_READ = 8'ha7;
  localparam logic [7:0] OP_PROT_MODE_READ = 8'h2b;
  localparam logic [7:0] OP_TRAINING_PATTERN_READ = 8'h41;
  localparam logic [7:0] OP_TRAINING_PATTERN_WRITE = 8'h4a;
  localparam logic [7:0] OP_ECC_REG_CLEAR = 8'hb6;
  localparam logic [7:0] OP_ECC_REG_READ = 8'hb3;
  localparam logic [7:0] OP_SECTOR_LOCK_CMD = 8'h24;
  localparam logic [7:0] OP_SECTOR_UNLOCK_CMD = 8'h26;
  localparam logic [7:0] OP_SECTOR_UNLOCK_CMD4 = 8'h25;
  localparam logic [7:0] OP_SUSPEND_CMD_A = 8'h75;
  localparam logic [7:0] OP_SUSPEND_CMD_B = 8'hb0;
  localparam logic [7:0] OP_PAGE_PROGRAM_CMD = 8'h02;
  localparam logic [7:0] OP_PAGE_PROGRAM_CMD4 = 8'h12;
  localparam logic [7:0] OP_QUAD_PAGE_PROGRAM_CMD = 8'h32;
  localparam logic [7:0] OP_QUAD_PAGE_PROGRAM_CMD4 = 8'h34;
  localparam logic [7:0] OP_QUAD_IO_PAGE_PROGRAM = 8'h38;
  localparam logic [7:0] OP_QUAD_IO_PAGE_PROGRAM4 = 8'h3e;
  localparam logic [7:0] OP_DYNAMIC_PROT_WRITE = 8'hfb;
  localparam logic [7:0] OP_ECC_REG_WRITE = 8'hb5;
  localparam logic [7:0] OP_POWER_DOWN_ENTRY_CMD = 8'hb9;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [3:0] {
    ST_ACTIVE = 4'b0001,
    ST_PD_ENTRY = 4'b0010,
    ST_PD = 4'b0100,
    ST_PD_EXIT = 4'b1000
  } srpf_state_t;

  typedef enum logic [1:0] {
    CL_NONE = 2'h0,
    CL_BOTH = 2'h1,
    CL_ERASE = 2'h2,
    CL_READ = 2'h3
  } srpf_class_t;

endpackage : srpf_pkg

/* File: hw/srpf_sync.sv */
`timescale 1ns/100ps
`default_nettype none

module srpf_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk_i,          // System clock
  input wire logic rst_n_i,        // Synchronous reset, active low
  input wire logic [W-1:0] d_i,    // Asynchronous inputs
  output logic [W-1:0] q_o         // Filtered, synchronised inputs
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
    end else begin
      s1 <= d_i;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // A bit changes only once stages two and three agree
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      q_o <= INIT;
    end else begin
      q_o <= (~(s2 ^ s3) & s3) | ((s2 ^ s3) & q_o);
    end
  end

endmodule : srpf_sync

`default_nettype wire

/* File: verif/srpf_filter_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
module srpf_filter_checker
  import srpf_pkg::*;
(
  input wire logic clk_i, // Clock
  input wire logic rst_n_i, // Reset
  input wire logic cs_n_i, // Chip select
  input wire logic sck_i, // Serial clock
  input wire logic [3:0] io_i, // Data pins
  input wire logic quad_command_mode_i, // Quad mode
  input wire logic write_in_progress_flag_i, // Busy
  input wire logic erase_suspend_set_i, // Erase pause set
  input wire logic program_suspend_set_i, // Program pause set
  input wire logic erase_hit_i, // Sector hit
  input wire logic cmd_valid_o, // Accepted
  input wire logic [7:0] cmd_code_o, // Code
  input wire logic cmd_refused_o, // Refused
  input wire logic resume_o, // Resume
  input wire logic read_block_o, // Read blocked
  input wire logic power_down_o, // Power-down
  input wire logic erase_paused_flag_o, // Erase paused
  input wire logic program_paused_flag_o, // Program paused
  input wire logic [7:0] function_reg_bits_o // Function bits
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  chk_one_outcome: assert property (!(cmd_valid_o && cmd_refused_o))
    else $error("accept and refuse together");
  chk_fn_bits_map: assert property (function_reg_bits_o == {4'h0, erase_paused_flag_o, program_paused_flag_o, 2'h0})
    else $error("function bits differ from pause flags");
  chk_erase_flag_set: assert property (erase_suspend_set_i |=> erase_paused_flag_o)
    else $error("erase pause flag not set");
  chk_resume_clears: assert property (resume_o && !$past(erase_suspend_set_i) && !$past(program_suspend_set_i)
    |-> !erase_paused_flag_o && !program_paused_flag_o)
    else $error("pause flag left set on resume");
  chk_resume_when_paused: assert property (resume_o |-> $past(erase_paused_flag_o || program_paused_flag_o))
    else $error("resume without pause");
  chk_resume_frame_end: assert property (resume_o |-> cs_n_i && $past(cs_n_i, 3))
    else $error("resume before chip select high");
  chk_flags_hold: assert property ($fell(erase_paused_flag_o) || $fell(program_paused_flag_o) |-> resume_o)
    else $error("pause flag cleared without resume");
  chk_pd_entry_wait: assert property ($rose(power_down_o) |-> $past(cs_n_i, 30))
    else $error("power-down entered inside frame");
  chk_pd_only_release: assert property (power_down_o && cmd_valid_o |-> cmd_code_o == OP_RELEASE_SIGNATURE_CMD)
    else $error("instruction accepted in power-down");
  chk_pd_exit_time: assert property ($fell(power_down_o) |-> $past(cs_n_i, 50))
    else $error("power-down left too early");
  chk_block_in_erase: assert property (read_block_o |-> erase_paused_flag_o)
    else $error("read refused outside erase pause");
endmodule : srpf_filter_checker

bind srpf_filter srpf_filter_checker u_chk (.clk_i, .rst_n_i, .cs_n_i, .sck_i, .io_i, .quad_command_mode_i,
  .write_in_progress_flag_i, .erase_suspend_set_i, .program_suspend_set_i, .erase_hit_i, .cmd_valid_o, .cmd_code_o,
  .cmd_refused_o, .resume_o, .read_block_o, .power_down_o, .erase_paused_flag_o, .program_paused_flag_o,
  .function_reg_bits_o);
`default_nettype wire

/* File: verif/srpf_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module srpf_host_model (
  input wire logic clk_i, // Clock
  output logic cs_n_o, // Chip select
  output logic sck_o, // Serial clock
  output logic [3:0] io_o // Data pins
);
  initial begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    io_o = 4'h0;
  end

  task automatic half(input int n);
    repeat (n) @(negedge clk_i);
  endtask : half

  // Clock idles low outside frames; released data shows the inverse
  task automatic frame(input logic [7:0] code, input logic quad, input int extra);
    int n;
    n = quad ? 2 : 8;
    cs_n_o = 1'b0;
    for (int i = 0; i < n + extra; i++) begin
      io_o = quad ? (i == 0 ? code[7:4] : code[3:0]) : {3'h0, code[7 - (i % 8)]};
      half(4);
      sck_o = 1'b1;
      half(4);
      sck_o = 1'b0;
    end
    half(8);
    cs_n_o = 1'b1;
    io_o = ~io_o;
    half(8);
  endtask : frame
endmodule : srpf_host_model
`default_nettype wire

/* File: verif/srpf_filter_tb.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) check_val(32'(g), 32'(e))
module srpf_filter_tb;
  import srpf_pkg::*;
  localparam logic [2:0] V = 3'h1;
  localparam logic [2:0] RF = 3'h2;
  localparam logic [2:0] RS = 3'h4;
  logic clk_i, rst_n_i, cs_n_i, sck_i, quad_command_mode_i, write_in_progress_flag_i;
  logic erase_suspend_set_i, program_suspend_set_i, erase_hit_i;
  logic [3:0] io_i;
  logic cmd_valid_o, cmd_refused_o, resume_o, read_block_o, power_down_o;
  logic erase_paused_flag_o, program_paused_flag_o;
  logic [7:0] cmd_code_o, function_reg_bits_o;
  logic [10:0] exp_q[$];
  int err_total = 0;
  int checks = 0;
  int n;
  logic [7:0] ops_both[$] = '{8'h03, 8'h13, 8'h0b, 8'h0c, 8'hbb, 8'hbc, 8'h3b, 8'h3c, 8'heb, 8'hec, 8'h6b, 8'h6c,
    8'h0d, 8'h0e, 8'hbd, 8'hbe, 8'hed, 8'hee, 8'h06, 8'h04, 8'h05, 8'h48, 8'h16, 8'hc8, 8'h61, 8'h81, 8'hab, 8'h9f,
    8'h90, 8'haf, 8'h4b, 8'h5a, 8'h82, 8'hc0, 8'h63, 8'h83, 8'h17, 8'hc5, 8'hb7, 8'h29, 8'hfc, 8'hf2, 8'hfa, 8'he0,
    8'he7, 8'ha7, 8'h2b, 8'h41, 8'h4a, 8'hb6, 8'hb3};
  logic [7:0] ops_erase[$] = '{8'h24, 8'h26, 8'h25, 8'h75, 8'hb0, 8'h02, 8'h12, 8'h32, 8'h34, 8'h38, 8'h3e,
    8'hfb, 8'hb5};
  logic [7:0] ops_bad[$] = '{8'h01, 8'h20, 8'hd8, 8'hc7, 8'h60, 8'h42, 8'h35};

  srpf_filter u_dut (.clk_i, .rst_n_i, .cs_n_i, .sck_i, .io_i, .quad_command_mode_i, .write_in_progress_flag_i,
    .erase_suspend_set_i, .program_suspend_set_i, .erase_hit_i, .cmd_valid_o, .cmd_code_o, .cmd_refused_o,
    .resume_o, .read_block_o, .power_down_o, .erase_paused_flag_o, .program_paused_flag_o, .function_reg_bits_o);
  srpf_host_model u_host (.clk_i, .cs_n_o(cs_n_i), .sck_o(sck_i), .io_o(io_i));

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_val

  task automatic wrap_up();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  // Kind zero expects no pulse at all from the frame
  task automatic send(input logic [7:0] code, input logic q, input int extra, input logic [2:0] kind);
    quad_command_mode_i = q;
    write_in_progress_flag_i = 1'($urandom % 2);
    if (kind != 3'h0) exp_q.push_back({kind, code});
    u_host.frame(code, q, extra);
  endtask : send

  task automatic pause(input logic erase);
    erase_suspend_set_i = erase;
    program_suspend_set_i = ~erase;
    @(negedge clk_i);
    erase_suspend_set_i = 1'b0;
    program_suspend_set_i = 1'b0;
    @(negedge clk_i);
    `CHK({erase_paused_flag_o, program_paused_flag_o, function_reg_bits_o}, erase ? 10'h208 : 10'h104);
  endtask : pause

  task automatic sweep(input logic erase);
    foreach (ops_both[i]) send(ops_both[i], 1'($urandom % 2), 0, V);
    foreach (ops_erase[i]) send(ops_erase[i], 1'($urandom % 2), 0, erase ? V : RF);
    foreach (ops_bad[i]) send(ops_bad[i], 1'($urandom % 2), 0, RF);
  endtask : sweep

  task automatic wait_pd(input logic lvl, output int cnt);
    cnt = 0;
    while (power_down_o !== lvl && cnt < 200) begin
      @(negedge clk_i);
      cnt++;
    end
    if (cnt >= 200) begin
      err_total++;
      wrap_up();
    end
  endtask : wait_pd

  always @(negedge clk_i) begin
    if ((cmd_valid_o || cmd_refused_o || resume_o) === 1'b1) begin
      if (exp_q.size() == 0) `CHK(1'b1, 1'b0);
      else `CHK({resume_o, cmd_refused_o, cmd_valid_o, cmd_code_o}, exp_q.pop_front());
    end
  end

  initial begin
    rst_n_i = 1'b0;
    quad_command_mode_i = 1'b0;
    write_in_progress_flag_i = 1'b0;
    erase_suspend_set_i = 1'b0;
    program_suspend_set_i = 1'b0;
    erase_hit_i = 1'b0;
    void'($urandom(71));
    repeat (6) @(negedge clk_i);
    rst_n_i = 1'b1;
    repeat (4) @(negedge clk_i);
    `CHK({cmd_valid_o, cmd_refused_o, resume_o, power_down_o, function_reg_bits_o}, 12'h000);
    send(8'h7a, 1'b0, 0, RF);
    pause(1'b0);
    sweep(1'b0);
    send(OP_POWER_DOWN_ENTRY_CMD, 1'b0, 0, RF);
    send(8'h7a, 1'b0, 0, RS);
    `CHK({power_down_o, function_reg_bits_o}, 9'h000);
    pause(1'b1);
    sweep(1'b1);
    erase_hit_i = 1'b1;
    fork
      send(8'h03, 1'b0, 0, V);
      begin
        repeat (70) @(negedge clk_i);
        `CHK(read_block_o, 1'b1);
      end
    join
    erase_hit_i = 1'b0;
    send(8'h30, 1'b1, 1, RF);
    `CHK(function_reg_bits_o, 8'h08);
    send(8'h30, 1'b1, 0, RS);
    `CHK(function_reg_bits_o, 8'h00);
    send(OP_POWER_DOWN_ENTRY_CMD, 1'b0, 3, RF);
    repeat (40) @(negedge clk_i);
    `CHK(power_down_o, 1'b0);
    for (int q = 0; q < 2; q++) begin
      send(OP_POWER_DOWN_ENTRY_CMD, 1'(q), 0, 3'h0);
      wait_pd(1'b1, n);
      `CHK(n >= 22 && n <= POWER_DOWN_ENTRY_CYC - 8, 1'b1);
      send(8'h05, 1'(q), 0, RF);
      send(8'h02, 1'(q), 0, RF);
      send(OP_RELEASE_SIGNATURE_CMD, 1'(q), 0, 3'h0);
      wait_pd(1'b0, n);
      `CHK(n >= POWER_DOWN_EXIT_CYC - 8 && n <= 55, 1'b1);
      send(8'h05, 1'(q), 0, V);
    end
    n = 0;
    while (exp_q.size() != 0 && n < 100) begin
      @(negedge clk_i);
      n++;
    end
    `CHK(exp_q.size(), 0);
    wrap_up();
  end
endmodule : srpf_filter_tb
`default_nettype wire
